// ---- shared/counter_bank_if.sv ----
// Signals between the register side and the error counter bank
`timescale 1ns/1ns
interface counter_bank_if;
  logic [one_second_pkg::NUM_COUNTERS-1:0] evt;
  logic tick;
  logic count_en;
  logic [one_second_pkg::CNT_W_MAX-1:0] latched [one_second_pkg::NUM_COUNTERS];
  logic [one_second_pkg::NUM_COUNTERS-1:0] saturated;

  modport bank (input evt, input tick, input count_en, output latched, output saturated);
  modport ctrl (output evt, output tick, output count_en, input latched, input saturated);
endinterface

// ---- shared/one_second_pkg.sv ----
// Constants, register map and field layout of the one-second error latch bank
package one_second_pkg;

  // Counter channels
  localparam int NUM_COUNTERS = 4;
  localparam int CNT_W_MAX = 16;
  localparam int CH_EBIT = 0;
  localparam int CH_ALIGN = 1;
  localparam int CH_BPV = 2;
  localparam int CH_CRC4 = 3;
  localparam int EBIT_W = 10;
  localparam int ALIGN_W = 8;
  localparam int BPV_W = 16;
  localparam int CRC4_W = 10;
  localparam int BYTE_W = 8;
  localparam int HI10_W = 2;

  // Register indices; byte address is four times the index
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_INT_STATUS = 6'h00;
  localparam logic [5:0] IDX_INT_MASK = 6'h01;
  localparam logic [5:0] IDX_CONTROL = 6'h02;
  localparam logic [5:0] IDX_EBIT_HI = 6'h10;
  localparam logic [5:0] IDX_EBIT_LO = 6'h11;
  localparam logic [5:0] IDX_ALIGN = 6'h12;
  localparam logic [5:0] IDX_BPV_HI = 6'h13;
  localparam logic [5:0] IDX_BPV_LO = 6'h14;
  localparam logic [5:0] IDX_CRC4_HI = 6'h15;
  localparam logic [5:0] IDX_CRC4_LO = 6'h16;
  localparam logic [5:0] IDX_PAGE_LAST = 6'h1F;
  localparam int IDX_LSB = 2;

  // Interrupt status and mask layout
  localparam int INT_W = 5;
  localparam int INT_SNAPSHOT = 0;
  localparam int INT_SAT_BASE = 1;
  localparam logic [4:0] INT_MASK_RESET = 5'h00;

  // Control register layout
  localparam int CTRL_W = 1;
  localparam int CTRL_COUNT_EN = 0;
  localparam logic [0:0] CTRL_RESET = 1'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Snapshot timing
  localparam int CLK_HZ = 125000000;
  localparam int SNAPSHOT_PERIOD_MS = 1000;
  localparam int SNAPSHOT_CYCLES = SNAPSHOT_PERIOD_MS * (CLK_HZ / 1000);

  // Width of each counter channel
  function automatic int cnt_width(input int ch);
    int w;
    w = EBIT_W;
    if (ch == CH_ALIGN) begin
      w = ALIGN_W;
    end else if (ch == CH_BPV) begin
      w = BPV_W;
    end else if (ch == CH_CRC4) begin
      w = CRC4_W;
    end
    return w;
  endfunction

endpackage

// ---- tb/e1_line_model.sv ----
// Far-end line model raising receive error pulses
`timescale 1ns/1ns
module e1_line_model (
  // Clock
  input wire logic aclk,
  // Pulses: E-bit, alignment, violation, CRC-4
  output logic [3:0] err_pulse
);
  initial err_pulse = 4'h0;
  // Pulse each channel n times, gap idle cycles apart
  task automatic send(input logic [15:0] n [4], input int gap);
    int most;
    most = 0;
    for (int k = 0; k < 4; k++) begin
      if (n[k] > most) most = n[k];
    end
    for (int i = 0; i < most; i++) begin
      @(posedge aclk);
      for (int k = 0; k < 4; k++) err_pulse[k] <= i < n[k];
      repeat (gap) begin
        @(posedge aclk);
        err_pulse <= 4'h0;
      end
    end
    @(posedge aclk);
    err_pulse <= 4'h0;
  endtask
endmodule

// ---- tb/latch_bank_checker.sv ----
// Assertions on the read side of the one-second error latch bank
`timescale 1ns/1ns
module latch_bank_checker #(
  parameter int TICK_CYCLES = 50,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Error events
  input wire logic ebit_err_pulse,
  input wire logic errored_align_pulse,
  input wire logic bipolar_violation_pulse,
  input wire logic crc4_err_pulse,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  logic [3:0] ev;
  logic [15:0] run_reg [4];
  logic [15:0] lat_reg [4];
  logic [15:0] cap_reg [4];
  logic [5:0] idx_reg;
  logic rd_new_reg;
  int tmr_reg;
  logic tick;
  assign ev = {crc4_err_pulse, bipolar_violation_pulse, errored_align_pulse, ebit_err_pulse};
  assign tick = tmr_reg == TICK_CYCLES - 1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One-second timer
  always_ff @(posedge aclk) begin
    tmr_reg <= (!aresetn || tick) ? 0 : tmr_reg + 1;
  end
  // Running counts and their snapshots
  always_ff @(posedge aclk) begin
    for (int k = 0; k < 4; k++) begin
      if (!aresetn) begin
        run_reg[k] <= 16'h0000;
        lat_reg[k] <= 16'h0000;
      end else begin
        run_reg[k] <= (tick ? 16'h0000 : run_reg[k]) + 16'(ev[k]);
        if (tick) begin
          lat_reg[k] <= run_reg[k];
        end
      end
    end
  end
  // Latch values seen at the read take
  always_ff @(posedge aclk) begin
    rd_new_reg <= aresetn && s_axi_arvalid && s_axi_arready;
    if (s_axi_arvalid && s_axi_arready) begin
      idx_reg <= s_axi_araddr[7:2];
      cap_reg <= lat_reg;
    end
  end
  property rd_p(logic [5:0] i, logic [31:0] v);
    rd_new_reg && idx_reg == i |-> s_axi_rvalid && s_axi_rdata == v;
  endproperty
  ebit_lo_a: assert property (rd_p(6'h11, {24'h0, cap_reg[0][7:0]}))
    else $error("E-bit low latch wrong");
  ebit_hi_a: assert property (rd_p(6'h10, {30'h0, cap_reg[0][9:8]}))
    else $error("E-bit high latch wrong");
  align_latch_a: assert property (rd_p(6'h12, {24'h0, cap_reg[1][7:0]}))
    else $error("alignment latch wrong");
  bpv_hi_a: assert property (rd_p(6'h13, {24'h0, cap_reg[2][15:8]}))
    else $error("violation high latch wrong");
  crc_hi_a: assert property (rd_p(6'h15, {30'h0, cap_reg[3][9:8]}))
    else $error("CRC-4 high latch wrong");
  unused_zero_a: assert property (rd_new_reg && idx_reg inside {[6'h17:6'h1F]}
    |-> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("unused offset not zero");
  cover property (tick && run_reg[2] != 16'h0000);
  cover property (rd_new_reg && idx_reg == 6'h14);
  cover property (rd_new_reg && idx_reg == 6'h16);
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the one-second error latch bank
`timescale 1ns/1ns
module tb;
  localparam int T = 5000;
  typedef struct {
    logic [15:0] n [4];
    int gap;
    logic [7:0] exp [7];
  } row_t;
  row_t rows [3] = '{
    '{'{16'h0003, 16'h0002, 16'h0105, 16'h0201}, 2,
      '{8'h00, 8'h03, 8'h02, 8'h01, 8'h05, 8'h02, 8'h01}},
    '{'{16'h02FF, 16'h00FF, 16'h1234, 16'h03A0}, 0,
      '{8'h02, 8'hFF, 8'hFF, 8'h12, 8'h34, 8'h03, 8'hA0}},
    '{'{16'h0, 16'h0, 16'h0, 16'h0}, 0, '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0}}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] err_pulse;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int compares = 0;
  initial forever #4 aclk = ~aclk;
  one_second_error_latches #(.TICK_CYCLES(T), .ADDR_W(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ebit_err_pulse(err_pulse[0]),
    .errored_align_pulse(err_pulse[1]), .bipolar_violation_pulse(err_pulse[2]),
    .crc4_err_pulse(err_pulse[3]), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  e1_line_model line_u (.aclk(aclk), .err_pulse(err_pulse));
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic tick_wait;
    logic [1:0] r;
    while (irq !== 1'b1) @(posedge aclk);
    wr(one_second_pkg::IDX_INT_STATUS, 32'h1, r);
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8 * T) @(posedge aclk);
    mismatches++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(one_second_pkg::IDX_ALIGN, d, r);
    chk("latch after reset", 32'h0, d);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("reset test done");
    wr(one_second_pkg::IDX_INT_MASK, 32'h1, r);
    tick_wait();
    for (int j = 0; j < 3; j++) begin
      line_u.send(rows[j].n, rows[j].gap);
      tick_wait();
      for (int k = 0; k < 7; k++) begin
        rd(6'(one_second_pkg::IDX_EBIT_HI + k), d, r);
        chk("latch", {24'h0, rows[j].exp[k]}, d);
      end
      $display("row %0d done", j);
    end
    rd(6'h20, d, r);
    chk("unmapped resp", {30'h0, one_second_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    rd(6'h17, d, r);
    chk("unused resp", {30'h0, one_second_pkg::RESP_OKAY}, {30'h0, r});
    chk("unused data", 32'h0, d);
    wr(one_second_pkg::IDX_BPV_LO, 32'hFF, r);
    rd(one_second_pkg::IDX_BPV_LO, d, r);
    chk("read-only latch", 32'h0, d);
    $display("address test done");
    wr(one_second_pkg::IDX_INT_MASK, 32'h0, r);
    repeat (T) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(one_second_pkg::IDX_INT_MASK, 32'h1, r);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(one_second_pkg::IDX_INT_STATUS, 32'h1, r);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("interrupt test done");
    close_out();
  end
endmodule
bind one_second_error_latches latch_bank_checker #(.TICK_CYCLES(TICK_CYCLES), .ADDR_W(ADDR_W)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .ebit_err_pulse(ebit_err_pulse),
  .errored_align_pulse(errored_align_pulse), .bipolar_violation_pulse(bipolar_violation_pulse),
  .crc4_err_pulse(crc4_err_pulse), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// ---- verilog/error_counter_bank.sv ----
// Running error counters and their one-second latched copies
`timescale 1ns/1ns
module error_counter_bank (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  counter_bank_if.bank bank
);

  genvar ch;
  generate
    for (ch = 0; ch < one_second_pkg::NUM_COUNTERS; ch++) begin : g_chan
      localparam int W = one_second_pkg::cnt_width(ch);
      logic [W-1:0] run_reg;
      logic [W-1:0] latch_reg;
      logic sat_reg;
      logic hit;
      logic at_max;

      assign hit = bank.evt[ch] && bank.count_en;
      assign at_max = (run_reg == {W{1'b1}});

      // Running count, restarted by each snapshot
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          run_reg <= '0;
        end else if (bank.tick) begin
          run_reg <= hit ? W'(1) : '0;
        end else if (hit && !at_max) begin
          run_reg <= run_reg + W'(1);
        end
      end

      // Snapshot copy
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          latch_reg <= '0;
        end else if (bank.tick) begin
          latch_reg <= run_reg;
        end
      end

      // Saturation event, one cycle
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sat_reg <= 1'b0;
        end else begin
          sat_reg <= hit && at_max && !bank.tick;
        end
      end

      assign bank.latched[ch] = one_second_pkg::CNT_W_MAX'(latch_reg);
      assign bank.saturated[ch] = sat_reg;
    end
  endgenerate

endmodule

// ---- verilog/one_second_error_latches.sv ----
// Top of the one-second error latch bank with AXI4-Lite register access
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module one_second_error_latches #(
  parameter int TICK_CYCLES = one_second_pkg::SNAPSHOT_CYCLES,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Error events from the receive framer
  input wire logic ebit_err_pulse,
  input wire logic errored_align_pulse,
  input wire logic bipolar_violation_pulse,
  input wire logic crc4_err_pulse,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam int NC = one_second_pkg::NUM_COUNTERS;
  localparam int IW = one_second_pkg::INT_W;
  localparam int IDX_LSB_HI = one_second_pkg::IDX_LSB + one_second_pkg::IDX_W - 1;

  counter_bank_if cbus ();

  error_counter_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .bank(cbus)
  );

  // One-second timer
  logic [TW-1:0] timer_reg;
  logic tick;

  assign tick = (timer_reg == TICK_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= '0;
    end else if (tick) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + TW'(1);
    end
  end

  // Control register
  logic [one_second_pkg::CTRL_W-1:0] control_reg;

  assign cbus.tick = tick;
  assign cbus.count_en = control_reg[one_second_pkg::CTRL_COUNT_EN];
  assign cbus.evt[one_second_pkg::CH_EBIT] = ebit_err_pulse;
  assign cbus.evt[one_second_pkg::CH_ALIGN] = errored_align_pulse;
  assign cbus.evt[one_second_pkg::CH_BPV] = bipolar_violation_pulse;
  assign cbus.evt[one_second_pkg::CH_CRC4] = crc4_err_pulse;

  // Write channel holding
  logic aw_held_reg;
  logic w_held_reg;
  logic [one_second_pkg::IDX_W-1:0] aw_idx_reg;
  logic aw_bad_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [one_second_pkg::IDX_W-1:0] aw_idx_in;
  logic aw_bad_in;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held_reg && w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign aw_idx_in = s_axi_awaddr[IDX_LSB_HI:one_second_pkg::IDX_LSB];
  assign aw_bad_in = (ADDR_W > IDX_LSB_HI + 1) ?
                     (s_axi_awaddr >> (IDX_LSB_HI + 1)) != '0 : 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      aw_bad_reg <= 1'b0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= aw_idx_in;
      aw_bad_reg <= aw_bad_in || (aw_idx_in > one_second_pkg::IDX_PAGE_LAST);
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= one_second_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= aw_bad_reg ? one_second_pkg::RESP_SLVERR : one_second_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  logic wr_low;

  assign wr_low = do_write && !aw_bad_reg && wstrb_reg[0];

  // Mask and control writes
  logic [IW-1:0] int_mask_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask_reg <= one_second_pkg::INT_MASK_RESET;
    end else if (wr_low && aw_idx_reg == one_second_pkg::IDX_INT_MASK) begin
      int_mask_reg <= wdata_reg[IW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= one_second_pkg::CTRL_RESET;
    end else if (wr_low && aw_idx_reg == one_second_pkg::IDX_CONTROL) begin
      control_reg <= wdata_reg[one_second_pkg::CTRL_W-1:0];
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  logic [IW-1:0] int_status_reg;
  logic [IW-1:0] int_set;
  logic [IW-1:0] int_clr;

  assign int_set = {cbus.saturated, tick};
  assign int_clr = (wr_low && aw_idx_reg == one_second_pkg::IDX_INT_STATUS) ?
                   wdata_reg[IW-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_reg <= '0;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clr) | int_set;
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // Read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  logic [one_second_pkg::IDX_W-1:0] ar_idx;
  logic ar_bad;
  logic ar_take;

  assign s_axi_arready = !rvalid_reg;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[IDX_LSB_HI:one_second_pkg::IDX_LSB];
  assign ar_bad = ((ADDR_W > IDX_LSB_HI + 1) ?
                   (s_axi_araddr >> (IDX_LSB_HI + 1)) != '0 : 1'b0) ||
                  (ar_idx > one_second_pkg::IDX_PAGE_LAST);
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  logic [one_second_pkg::CNT_W_MAX-1:0] lat_ebit;
  logic [one_second_pkg::CNT_W_MAX-1:0] lat_align;
  logic [one_second_pkg::CNT_W_MAX-1:0] lat_bpv;
  logic [one_second_pkg::CNT_W_MAX-1:0] lat_crc4;

  assign lat_ebit = cbus.latched[one_second_pkg::CH_EBIT];
  assign lat_align = cbus.latched[one_second_pkg::CH_ALIGN];
  assign lat_bpv = cbus.latched[one_second_pkg::CH_BPV];
  assign lat_crc4 = cbus.latched[one_second_pkg::CH_CRC4];

  always_comb begin
    rdata_next = '0;
    rresp_next = one_second_pkg::RESP_OKAY;
    if (ar_bad) begin
      rresp_next = one_second_pkg::RESP_SLVERR;
    end else if (ar_idx == one_second_pkg::IDX_INT_STATUS) begin
      rdata_next = 32'(int_status_reg);
    end else if (ar_idx == one_second_pkg::IDX_INT_MASK) begin
      rdata_next = 32'(int_mask_reg);
    end else if (ar_idx == one_second_pkg::IDX_CONTROL) begin
      rdata_next = 32'(control_reg);
    end else if (ar_idx == one_second_pkg::IDX_EBIT_HI) begin
      rdata_next = 32'(lat_ebit[one_second_pkg::EBIT_W-1:one_second_pkg::BYTE_W]);
    end else if (ar_idx == one_second_pkg::IDX_EBIT_LO) begin
      rdata_next = 32'(lat_ebit[one_second_pkg::BYTE_W-1:0]);
    end else if (ar_idx == one_second_pkg::IDX_ALIGN) begin
      rdata_next = 32'(lat_align[one_second_pkg::ALIGN_W-1:0]);
    end else if (ar_idx == one_second_pkg::IDX_BPV_HI) begin
      rdata_next = 32'(lat_bpv[one_second_pkg::BPV_W-1:one_second_pkg::BYTE_W]);
    end else if (ar_idx == one_second_pkg::IDX_BPV_LO) begin
      rdata_next = 32'(lat_bpv[one_second_pkg::BYTE_W-1:0]);
    end else if (ar_idx == one_second_pkg::IDX_CRC4_HI) begin
      rdata_next = 32'(lat_crc4[one_second_pkg::CRC4_W-1:one_second_pkg::BYTE_W]);
    end else if (ar_idx == one_second_pkg::IDX_CRC4_LO) begin
      rdata_next = 32'(lat_crc4[one_second_pkg::BYTE_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= one_second_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule
